//--- cwm_pkg.sv
package cwm_pkg;
  // clock and oscillator timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned OSC_TICK_US = 512;
  localparam int unsigned OSC_TICK_CYCLES = (OSC_TICK_US * 1000) / CLK_PERIOD_NS;
  // wake periods in ms and in oscillator ticks
  localparam int unsigned WAKE_MS_48 = 48;
  localparam int unsigned WAKE_MS_96 = 96;
  localparam int unsigned WAKE_MS_192 = 192;
  localparam int unsigned WAKE_TICKS_48 = 94;
  localparam int unsigned WAKE_TICKS_96 = 188;
  localparam int unsigned WAKE_TICKS_192 = 376;
  localparam int unsigned WAKE_TICK_W = 9;
  // long open watchdog window, in oscillator ticks
  localparam int unsigned LONG_WIN_TICKS = 256;
  // least high time of a pwm sleep request
  localparam int unsigned PWM_MIN_HIGH = 4;
  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_WD_TRIG = 8'h10;
  // control word fields
  localparam int unsigned BIT_HS1 = 1;
  localparam int unsigned BIT_HS2 = 2;
  localparam int unsigned BIT_HS3 = 3;
  localparam int unsigned BIT_LS1 = 4;
  localparam int unsigned BIT_LS2 = 5;
  localparam int unsigned BIT_UVS = 6;
  localparam int unsigned BIT_MODE_LO = 9;
  localparam int unsigned BIT_MODE_HI = 10;
  localparam int unsigned BIT_PWM_EN = 11;
  localparam int unsigned BIT_PER_LO = 12;
  localparam int unsigned BIT_PER_HI = 13;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_SW_MASK = 16'h007e;
  localparam logic [15:0] CTRL_MODE_MASK = 16'h0600;
  // interrupt status bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_TIMER = 0;
  localparam int unsigned IRQ_CAN = 1;
  localparam int unsigned IRQ_PIN = 2;
  localparam int unsigned IRQ_WD = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  // operating modes, mode_select_high then mode_select_low
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_RX_ONLY = 2'b01,
    MODE_CYCLIC = 2'b10,
    MODE_NORMAL = 2'b11
  } mode_t;

  // wake period code
  typedef enum logic [1:0] {
    PER_48 = 2'b00,
    PER_96 = 2'b01,
    PER_192 = 2'b10,
    PER_NONE = 2'b11
  } period_t;

  // sequencer states, gray along run, awake, sleep
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_AWAKE = 2'b01,
    ST_SLEEP = 2'b11
  } cw_state_t;

  // function gates towards the analog parts
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic hs1;
    logic hs2;
    logic hs3;
    logic ls1;
    logic ls2;
    logic uv_sup;
    logic rtl_vcc;
    logic rth_gnd;
    logic spi_en;
  } sw_out_t;
endpackage

//--- osc_tick_gen.sv
`timescale 1ns/1ps
// divides the clock down to the oscillator tick
module osc_tick_gen #(
  parameter int unsigned TICK_CYCLES = cwm_pkg::OSC_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cnt_q; // cycles within one tick

  // free-running prescaler, one-cycle pulse per tick
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == CW'(TICK_CYCLES - 1)) begin
      cnt_q <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // osc_tick_gen

//--- wake_timer.sv
`timescale 1ns/1ps
// counts oscillator ticks in sleep up to the programmed period
module wake_timer
  import cwm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_restart,
  input wire logic i_run,
  input period_t i_code,
  output logic o_expire
);
  logic [WAKE_TICK_W-1:0] cnt_q; // ticks since sleep entry
  logic [WAKE_TICK_W-1:0] target; // ticks of current code

  // period code to tick count
  always_comb begin
    case (i_code)
      PER_48: target = WAKE_TICK_W'(WAKE_TICKS_48);
      PER_96: target = WAKE_TICK_W'(WAKE_TICKS_96);
      PER_192: target = WAKE_TICK_W'(WAKE_TICKS_192);
      default: target = '0;
    endcase
  end

  // expiry on the tick that completes the period
  assign o_expire = i_run && i_tick && (i_code != PER_NONE) &&
                    (cnt_q == target - 1'b1);

  // restart on entry, hold when timed wake is off
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_restart) begin
      cnt_q <= '0;
    end else if (i_run && i_tick && i_code != PER_NONE) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // wake_timer

//--- cyclic_wake_mode_control.sv
`timescale 1ns/1ps
module cyclic_wake_mode_control
  import cwm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = OSC_TICK_CYCLES,
  parameter int unsigned WIN_TICKS = LONG_WIN_TICKS,
  parameter int unsigned PWM_MIN = PWM_MIN_HIGH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_pwm,
  input wire logic i_wake_input_pin,
  input wire logic i_can_wake,
  input wire logic i_bus_rx,
  output sw_out_t o_sw,
  output logic o_rxd,
  output logic o_wd_reset,
  output logic o_irq
);
  localparam int unsigned WW = $clog2(WIN_TICKS + 1);
  localparam int unsigned PW = $clog2(PWM_MIN + 1);

  // true for the two low-power modes of the control word
  function automatic logic is_low_power(input mode_t m);
    return (m == MODE_STANDBY) || (m == MODE_CYCLIC);
  endfunction

  // state and registers
  cw_state_t state_q; // sequencer state
  cw_state_t state_d; // next sequencer state
  logic [15:0] ctrl_q; // control word
  logic [IRQ_W-1:0] irq_stat_q; // sticky events
  logic [IRQ_W-1:0] irq_stat_d; // next sticky events
  logic [IRQ_W-1:0] irq_mask_q; // interrupt enables
  logic [WW-1:0] win_q; // ticks in open window
  logic [PW-1:0] pwm_hi_q; // cycles pwm has been high
  logic pwm_prev_q; // pwm level last cycle
  logic wk_prev_q; // wake pin level last cycle
  logic can_wk_q; // can wake pending
  sw_out_t sw_d; // next function gates
  logic rxd_d; // next receive output

  // bus and event terms
  logic acc; // access completing this edge
  logic wr; // write completing
  logic ctrl_wr; // control word written
  logic trig_wr; // watchdog trigger written
  logic tick; // oscillator tick
  logic timer_exp; // wake period elapsed
  logic win_exp; // open window elapsed
  logic pwm_ok; // valid sleep request
  logic pin_rise; // wake pin rising edge
  logic wd_fire; // watchdog reset this cycle
  logic can_set; // can wake to latch
  mode_t mode; // selected mode
  period_t per; // selected wake period

  assign mode = mode_t'(ctrl_q[BIT_MODE_HI:BIT_MODE_LO]);
  assign per = period_t'(ctrl_q[BIT_PER_HI:BIT_PER_LO]);

  // apb access phase ends one cycle after it starts
  assign acc = i_psel && i_penable && o_pready;
  assign wr = acc && i_pwrite;
  // control and trigger writes are dropped while asleep
  assign ctrl_wr = wr && (i_paddr == ADDR_CTRL) && (state_q != ST_SLEEP);
  assign trig_wr = wr && (i_paddr == ADDR_WD_TRIG) && (state_q != ST_SLEEP);

  // oscillator tick source
  osc_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  // wake period timer, restarted on every sleep entry
  wake_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_restart(state_d == ST_SLEEP && state_q != ST_SLEEP),
    .i_run(state_q == ST_SLEEP),
    .i_code(per),
    .o_expire(timer_exp)
  );

  // wake pin looked at only while asleep
  assign pin_rise = (state_q == ST_SLEEP) && i_wake_input_pin && !wk_prev_q;
  // sleep request: pwm high long enough, then falls
  assign pwm_ok = (state_q == ST_AWAKE) && pwm_prev_q && !i_pwm &&
                  (pwm_hi_q == PW'(PWM_MIN));
  // window ends on the last tick
  assign win_exp = (state_q == ST_AWAKE) && tick && (win_q == WW'(WIN_TICKS - 1));
  assign wd_fire = win_exp && !trig_wr && !pwm_ok;
  // can wake counts in stand-by and both cyclic states
  assign can_set = i_can_wake &&
                   ((state_q != ST_RUN) || (mode == MODE_STANDBY));

  // next sequencer state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        // entering cyclic wake goes to awake first
        if (mode == MODE_CYCLIC && !wd_fire) begin
          state_d = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        if (wd_fire) begin
          state_d = ST_RUN;
        end else if (mode != MODE_CYCLIC) begin
          state_d = ST_RUN;
        end else if (pwm_ok) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // any of three wake sources
        if (timer_exp || i_can_wake || pin_rise) begin
          state_d = ST_AWAKE;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // sequencer state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // control word, cleared by reset, switch and mode fields cleared by watchdog reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wd_fire) begin
      ctrl_q <= ctrl_q & ~(CTRL_SW_MASK | CTRL_MODE_MASK);
    end else if (ctrl_wr) begin
      ctrl_q <= i_pwdata[15:0];
    end
  end

  // long open window counter, restarted on awake entry
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      win_q <= '0;
    end else if (state_d == ST_AWAKE && state_q != ST_AWAKE) begin
      win_q <= '0;
    end else if (trig_wr) begin
      win_q <= '0; // valid trigger reopens window
    end else if (state_q == ST_AWAKE && tick && !win_exp) begin
      win_q <= win_q + 1'b1;
    end
  end

  // pwm high-time counter, saturating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwm_hi_q <= '0;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_prev_q <= i_pwm;
      if (!i_pwm) begin
        pwm_hi_q <= '0;
      end else if (pwm_hi_q != PW'(PWM_MIN)) begin
        pwm_hi_q <= pwm_hi_q + 1'b1;
      end
    end
  end

  // wake pin edge history
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wk_prev_q <= 1'b0;
    end else begin
      wk_prev_q <= i_wake_input_pin;
    end
  end

  // can wake latch, set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      can_wk_q <= 1'b0;
    end else if (can_set) begin
      can_wk_q <= 1'b1;
    end else if (!is_low_power(mode)) begin
      can_wk_q <= 1'b0;
    end
  end

  // function gates for each state
  always_comb begin
    sw_d = '0;
    sw_d.rth_gnd = 1'b1;
    case (state_q)
      ST_RUN: begin
        sw_d.tx_en = (mode == MODE_NORMAL);
        sw_d.rx_en = !is_low_power(mode);
        // bit 1 gates the pwm pin when pwm is enabled
        sw_d.hs1 = ctrl_q[BIT_HS1] && (!ctrl_q[BIT_PWM_EN] || i_pwm);
        sw_d.hs2 = ctrl_q[BIT_HS2];
        sw_d.hs3 = ctrl_q[BIT_HS3];
        sw_d.ls1 = ctrl_q[BIT_LS1];
        sw_d.ls2 = ctrl_q[BIT_LS2];
        sw_d.uv_sup = ctrl_q[BIT_UVS];
        sw_d.rtl_vcc = !is_low_power(mode);
        sw_d.spi_en = 1'b1;
      end
      ST_AWAKE: begin
        // only third switch may run
        sw_d.hs3 = ctrl_q[BIT_HS3];
        sw_d.uv_sup = ctrl_q[BIT_UVS];
        sw_d.spi_en = 1'b1;
      end
      default: begin
        sw_d.spi_en = 1'b0;
      end
    endcase
  end

  // receive output source
  always_comb begin
    if (state_q == ST_RUN && !is_low_power(mode)) begin
      rxd_d = i_bus_rx;
    end else if (state_q == ST_SLEEP) begin
      rxd_d = 1'b1; // low shows once awake
    end else begin
      rxd_d = !can_wk_q;
    end
  end

  // registered pin outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sw <= '0;
      o_rxd <= 1'b1;
      o_wd_reset <= 1'b0;
    end else begin
      o_sw <= sw_d;
      o_rxd <= rxd_d;
      o_wd_reset <= wd_fire;
    end
  end

  // sticky events, set wins over write-one clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr && i_paddr == ADDR_IRQ_STAT) begin
      irq_stat_d = irq_stat_d & ~i_pwdata[IRQ_W-1:0];
    end
    irq_stat_d[IRQ_TIMER] = irq_stat_d[IRQ_TIMER] | timer_exp;
    irq_stat_d[IRQ_CAN] = irq_stat_d[IRQ_CAN] | can_set;
    irq_stat_d[IRQ_PIN] = irq_stat_d[IRQ_PIN] | pin_rise;
    irq_stat_d[IRQ_WD] = irq_stat_d[IRQ_WD] | wd_fire;
  end

  // interrupt registers and output
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_stat_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
      o_irq <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      o_irq <= |(irq_stat_d & irq_mask_q);
      if (wr && i_paddr == ADDR_IRQ_MASK) begin
        irq_mask_q <= i_pwdata[IRQ_W-1:0];
      end
    end
  end

  // apb slave: one wait state, read data loaded with ready
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else if (i_psel && i_penable && !o_pready) begin
      o_pready <= 1'b1;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      if (i_paddr == ADDR_CTRL) begin
        o_prdata <= {16'h0000, ctrl_q};
      end else if (i_paddr == ADDR_STATUS) begin
        o_prdata <= {29'h0000000, can_wk_q, state_q};
      end else if (i_paddr == ADDR_IRQ_STAT) begin
        o_prdata <= {28'h0000000, irq_stat_q};
      end else if (i_paddr == ADDR_IRQ_MASK) begin
        o_prdata <= {28'h0000000, irq_mask_q};
      end else if (i_paddr == ADDR_WD_TRIG) begin
        o_prdata <= '0;
      end else begin
        o_pslverr <= 1'b1; // unmapped address
      end
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_win_restart;
    (state_d == ST_AWAKE && state_q != ST_AWAKE) |=> (win_q == '0);
  endproperty
  a_win_restart: assert property (p_win_restart)
    else $error("window not restarted on awake entry");

  property p_awake_off;
    state_q == ST_AWAKE |=> !o_sw.tx_en && !o_sw.rx_en && !o_sw.hs1 &&
                            !o_sw.hs2 && !o_sw.ls1 && !o_sw.ls2;
  endproperty
  a_awake_off: assert property (p_awake_off)
    else $error("function active in awake state");

  property p_wd_fire;
    (win_exp && !trig_wr && !pwm_ok) |=> o_wd_reset ##1 !o_wd_reset;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog reset missing after window");

  property p_sleep_cause;
    (state_q == ST_AWAKE ##1 state_q == ST_SLEEP) |-> $past(pwm_ok);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause)
    else $error("sleep entered without pwm trigger");

  property p_sleep_off;
    state_q == ST_SLEEP |=> !o_sw.hs3 && !o_sw.spi_en && !o_sw.uv_sup;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("function active in sleep");

  property p_timer_wake;
    (state_q == ST_SLEEP && timer_exp) |=> state_q == ST_AWAKE;
  endproperty
  a_timer_wake: assert property (p_timer_wake)
    else $error("timer expiry did not wake");

  property p_pin_wake;
    (state_q == ST_SLEEP && i_wake_input_pin && !wk_prev_q) |=> state_q == ST_AWAKE;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("wake pin edge did not wake");

  property p_no_timed;
    per == PER_NONE |-> !timer_exp;
  endproperty
  a_no_timed: assert property (p_no_timed)
    else $error("timed wake while disabled");

  property p_wd_standby;
    o_wd_reset |-> (ctrl_q & (CTRL_SW_MASK | CTRL_MODE_MASK)) == 16'h0000;
  endproperty
  a_wd_standby: assert property (p_wd_standby)
    else $error("enables survive watchdog reset");

  property p_rxd_can;
    (state_q == ST_AWAKE && can_wk_q) |=> !o_rxd;
  endproperty
  a_rxd_can: assert property (p_rxd_can)
    else $error("receive output not low after can wake");

  property p_term;
    (state_q == ST_RUN && mode == MODE_NORMAL) |=> o_sw.rtl_vcc && o_sw.rth_gnd;
  endproperty
  a_term: assert property (p_term)
    else $error("termination wrong in normal mode");

  c_sleep: cover property (state_q == ST_AWAKE ##1 state_q == ST_SLEEP);
  c_pin: cover property (state_q == ST_SLEEP && pin_rise);
  c_timer: cover property (state_q == ST_SLEEP && timer_exp);
  c_wd: cover property (o_wd_reset);
endmodule // cyclic_wake_mode_control

//--- host_pwm_model.sv
`timescale 1ns/1ps
// host side of the pwm pin: a steady level plus timed pulses
module host_pwm_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [7:0] i_len,
  input wire logic i_hold,
  output logic o_pwm
);
  logic [7:0] left_q; // pulse cycles still to run
  // load a pulse on request, then count down to zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      left_q <= 8'h00;
    end else if (i_go) begin
      left_q <= i_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // pin high during a pulse or while the level asks for it
  assign o_pwm = i_hold | (left_q != 8'h00);
endmodule // host_pwm_model

//--- tb_cyclic_wake_mode_control.sv
`timescale 1ns/1ps
module tb_cyclic_wake_mode_control
  import cwm_pkg::*;
;
  localparam int TK = 4; // clocks per oscillator tick
  localparam int WIN = 64; // long window in ticks
  localparam int PMIN = 4; // least pwm high time
  localparam logic [10:0] SW_AWAKE = 11'h04b; // hs3, supervisor, rth, serial
  localparam logic [10:0] SW_SLEEP = 11'h002; // rth only
  localparam logic [10:0] SW_STBY = 11'h003; // rth and serial
  logic i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic rerr, pwm_go, pwm_hold, pwm, wake_pin, can_wake, bus_rx, rxd, wd_reset, irq;
  logic [7:0] pwm_len;
  sw_out_t sw;
  int mismatches, comparisons, n;
  int per[3] = '{94, 188, 376}; // wake period in ticks per code
  logic [15:0] mctl[3] = '{16'h067e, 16'h027e, 16'h007e}; // normal, rx-only, stand-by
  logic [10:0] msw[3] = '{11'h7ff, 11'h3ff, 11'h1fb}; // gates expected per mode

  cyclic_wake_mode_control #(.TICK_CYCLES(TK), .WIN_TICKS(WIN), .PWM_MIN(PMIN)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pwm(pwm), .i_wake_input_pin(wake_pin),
    .i_can_wake(can_wake), .i_bus_rx(bus_rx), .o_sw(sw), .o_rxd(rxd),
    .o_wd_reset(wd_reset), .o_irq(irq));

  host_pwm_model host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(pwm_go), .i_len(pwm_len),
    .i_hold(pwm_hold), .o_pwm(pwm));

  // free running clock
  always #2.5 i_clk = ~i_clk;

  // counts, verdict and end of run
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // compare a value
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare the function gates
  task chk_sw(input string what, input logic [10:0] exp);
    comparisons++;
    if (sw !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, sw);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // one apb transfer, held until pready is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    k = 0;
    // wait for the answer however long it takes, the hang guard ends a stall
    do begin
      @(posedge i_clk);
      k++;
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready_wait", 32'h2, k); // one wait state per access
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask

  // pwm pulse from the host, then let the state settle
  task sleep_req(input logic [7:0] len);
    @(posedge i_clk);
    pwm_go <= 1'b1;
    pwm_len <= len;
    @(posedge i_clk);
    pwm_go <= 1'b0;
    cyc(int'(len) + 4);
  endtask

  // cycles from here until the awake gates show, inside a window
  task wait_awake(input int lo, input int hi);
    n = 0;
    while (sw !== SW_AWAKE && n < hi) begin
      @(posedge i_clk);
      n++;
    end
    chk("wake_delay_ok", 32'h1, {31'h0, (n >= lo && n < hi)});
  endtask

  // hang guard
  initial begin
    #200000;
    mismatches++;
    conclude;
  end

  // main sequence
  initial begin
    i_clk = 1'b0; i_rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pwm_go = 1'b0; pwm_len = 8'h00; pwm_hold = 1'b0;
    wake_pin = 1'b0; can_wake = 1'b0; bus_rx = 1'b1;
    mismatches = 0; comparisons = 0;
    cyc(10);
    i_rst_n <= 1'b1;
    cyc(1);
    chk_sw("sw_reset", 11'h000);
    chk("rxd_reset", 32'h1, {31'h0, rxd});
    rd("ctrl_reset", ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    wr(ADDR_IRQ_MASK, 32'hf);
    rd("irq_mask", ADDR_IRQ_MASK, 32'hf);
    // each non-cyclic mode with every switch enabled
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, {16'h0, mctl[i]});
      cyc(3);
      chk_sw("sw_mode", msw[i]);
    end
    // bus wake in stand-by pulls receive output low
    can_wake <= 1'b1;
    cyc(1);
    can_wake <= 1'b0;
    cyc(3);
    chk("rxd_can_standby", 32'h0, {31'h0, rxd});
    rd("irq_can", ADDR_IRQ_STAT, 32'h2);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h2);
    cyc(2);
    chk("irq_clear", 32'h0, {31'h0, irq});
    // first switch drive from bit 1 and the pwm pin
    wr(ADDR_CTRL, 32'h0e02);
    cyc(3);
    chk_sw("hs1_pwm_low", 11'h607);
    pwm_hold <= 1'b1;
    cyc(3);
    chk_sw("hs1_pwm_high", 11'h707);
    wr(ADDR_CTRL, 32'h0e00);
    cyc(3);
    chk_sw("hs1_masked", 11'h607);
    // receive output follows the bus in normal mode
    bus_rx <= 1'b0;
    cyc(3);
    chk("rxd_follows_bus", 32'h0, {31'h0, rxd});
    bus_rx <= 1'b1;
    pwm_hold <= 1'b0;
    // wake pin outside sleep is ignored
    wake_pin <= 1'b1;
    cyc(3);
    wake_pin <= 1'b0;
    rd("pin_ignored", ADDR_IRQ_STAT, 32'h0);
    // timed wake for each period code
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'h0448 | (i << 12));
      cyc(3);
      chk_sw("sw_awake", SW_AWAKE);
      rd("status_awake", ADDR_STATUS, 32'h1);
      if (i == 0) begin
        sleep_req(8'(PMIN - 2));
        chk_sw("short_pwm_refused", SW_AWAKE);
      end
      sleep_req(8'(PMIN + 2));
      chk_sw("sw_sleep", SW_SLEEP);
      rd("status_sleep", ADDR_STATUS, 32'h3);
      wait_awake((per[i] - 1) * TK - 16, (per[i] + 1) * TK + 8);
    end
    rd("irq_timer", ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    // no timed wake, then pin wake
    wr(ADDR_CTRL, 32'h3448);
    cyc(3);
    sleep_req(8'(PMIN + 2));
    // control write dropped while asleep, reads still answer
    wr(ADDR_CTRL, 32'h0648);
    rd("ctrl_refused", ADDR_CTRL, 32'h3448);
    cyc(400 * TK);
    chk_sw("no_timed_wake", SW_SLEEP);
    wake_pin <= 1'b1;
    cyc(4);
    chk_sw("pin_wake", SW_AWAKE);
    wake_pin <= 1'b0;
    // bus wake from sleep
    sleep_req(8'(PMIN + 2));
    can_wake <= 1'b1;
    cyc(1);
    can_wake <= 1'b0;
    cyc(4);
    chk_sw("can_wake", SW_AWAKE);
    chk("rxd_can_wake", 32'h0, {31'h0, rxd});
    rd("irq_pin_can", ADDR_IRQ_STAT, 32'h6);
    wr(ADDR_IRQ_STAT, 32'h6);
    // trigger restarts the window, then expiry gives a reset
    cyc(100);
    wr(ADDR_WD_TRIG, 32'h1);
    n = 0;
    while (wd_reset !== 1'b1 && n < WIN * TK + 40) begin
      @(posedge i_clk);
      n++;
    end
    chk("wd_delay_ok", 32'h1, {31'h0, (n >= (WIN - 1) * TK - 8 && n < WIN * TK + 40)});
    cyc(3);
    chk_sw("sw_after_wd", SW_STBY);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_after_wd", 32'h0, rdata & 32'h067e);
    rd("irq_wd", ADDR_IRQ_STAT, 32'h8);
    // masking of the interrupt line
    wr(ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h8);
    cyc(2);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h8);
    cyc(2);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    conclude;
  end
endmodule // tb_cyclic_wake_mode_control
